// ===== shared/poc_pkg.sv
// package for the pwm pin output control block
package poc_pkg;

    // pin pair output mode encodings
    localparam logic [1:0] MODE_INDEPENDENT = 2'h3;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
    localparam logic [1:0] MODE_REDUNDANT = 2'h1;
    localparam logic [1:0] MODE_COMPLEMENTARY = 2'h0;

    // bit positions inside the two-bit override and fault fields
    localparam int unsigned VALUE_HIGH_BIT = 1;
    localparam int unsigned VALUE_LOW_BIT = 0;

    // normal fault mode is selected by independent_fault_sel at this value
    localparam logic FAULT_MODE_NORMAL = 1'h0;

    // values after reset
    localparam logic HIGH_PIN_RESET = 1'h0;
    localparam logic LOW_PIN_RESET = 1'h0;
    localparam logic GEN_HIGH_RESET = 1'h0;

    // push-pull steering phase, one-hot
    typedef enum logic [1:0] {
        POC_PH_HIGH = 2'h1,
        POC_PH_LOW = 2'h2
    } poc_phase_t;

    // low phase after reset, so the first period lands on the high pin
    localparam poc_phase_t PHASE_RESET = POC_PH_LOW;

    // static configuration of one pin pair
    typedef struct packed {
        logic [1:0] pin_pair_mode;
        logic low_polarity_inv;
        logic override_enable_high;
        logic override_enable_low;
        logic [1:0] override_value_field;
        logic [1:0] fault_value_field;
        logic independent_fault_sel;
    } poc_cfg_t;

    // raw generator waveforms
    typedef struct packed {
        logic high;
        logic low;
    } poc_wave_t;

endpackage

// ===== logic/poc_mode_mux.sv
// pin pair mode steering of the generator waveforms
module poc_mode_mux (
    input wire logic [1:0] pin_pair_mode,
    input wire poc_pkg::poc_wave_t gen,
    input wire poc_pkg::poc_phase_t phase,
    output poc_pkg::poc_wave_t raw
);
    import poc_pkg::*;

    always_comb begin
        raw = '0;
        case (pin_pair_mode)
            MODE_INDEPENDENT: begin
                raw.high = gen.high;
                raw.low = gen.low;
            end
            MODE_PUSH_PULL: begin
                // one pin per period, alternating
                raw.high = gen.high & (phase == POC_PH_HIGH);
                raw.low = gen.high & (phase == POC_PH_LOW);
            end
            MODE_REDUNDANT: begin
                raw.high = gen.high;
                raw.low = gen.high;
            end
            default: begin
                raw.high = gen.high;
                raw.low = ~gen.high;
            end
        endcase
    end

endmodule // poc_mode_mux

// ===== logic/poc_pin_ctrl.sv
// output stage of one pwm generator pin pair
// Functional notes
// - low polarity bit set makes low pin active-low
// - mode field picks independent, push-pull, redundant, complementary
// - high override enable drives high pin from bit1
// - low override enable drives low pin from bit0
// - normal mode fault forces high pin to bit1
// - normal mode fault forces low pin to bit0
module poc_pin_ctrl (
    core_clk,
    reset_n,
    cfg,
    gen,
    fault_active,
    high_side_pin,
    low_side_pin
);
    import poc_pkg::*;

    input wire logic core_clk;
    input wire logic reset_n;
    input wire poc_pkg::poc_cfg_t cfg;
    input wire poc_pkg::poc_wave_t gen;
    input wire logic fault_active;
    output logic high_side_pin;
    output logic low_side_pin;

    poc_wave_t raw;
    poc_phase_t phase_r;
    poc_phase_t phase_nxt;
    logic gen_high_r;
    logic gen_high_nxt;
    logic high_pin_r;
    logic high_pin_nxt;
    logic low_pin_r;
    logic low_pin_nxt;
    logic fault_force;

    // next phase, so a new period never starts on the previous pin
    poc_mode_mux u_mode_mux (
        .pin_pair_mode(cfg.pin_pair_mode),
        .gen(gen),
        .phase(phase_nxt),
        .raw(raw)
    );

    // only normal fault mode is handled here
    assign fault_force = fault_active &
        (cfg.independent_fault_sel == FAULT_MODE_NORMAL);

    // push-pull phase flips on each rising edge of the high waveform
    always_comb begin
        gen_high_nxt = gen.high;
        phase_nxt = phase_r;
        if (gen.high && !gen_high_r) begin
            case (phase_r)
                POC_PH_HIGH: phase_nxt = POC_PH_LOW;
                POC_PH_LOW: phase_nxt = POC_PH_HIGH;
                default: phase_nxt = POC_PH_HIGH;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= PHASE_RESET;
            gen_high_r <= GEN_HIGH_RESET;
        end else begin
            phase_r <= phase_nxt;
            gen_high_r <= gen_high_nxt;
        end
    end

    // priority: fault, then override, then generator.
    // the fault value is the pin state itself so polarity is not applied,
    // a safe state must not depend on another setting.
    always_comb begin
        high_pin_nxt = raw.high;
        low_pin_nxt = raw.low ^ cfg.low_polarity_inv;
        if (fault_force) begin
            high_pin_nxt = cfg.fault_value_field[VALUE_HIGH_BIT];
        end else if (cfg.override_enable_high) begin
            high_pin_nxt = cfg.override_value_field[VALUE_HIGH_BIT];
        end
        if (fault_force) begin
            low_pin_nxt = cfg.fault_value_field[VALUE_LOW_BIT];
        end else if (cfg.override_enable_low) begin
            low_pin_nxt = cfg.override_value_field[VALUE_LOW_BIT] ^
                cfg.low_polarity_inv;
        end
    end

    // registered so the pins never glitch through the mux
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_pin_r <= HIGH_PIN_RESET;
            low_pin_r <= LOW_PIN_RESET;
        end else begin
            high_pin_r <= high_pin_nxt;
            low_pin_r <= low_pin_nxt;
        end
    end

    assign high_side_pin = high_pin_r;
    assign low_side_pin = low_pin_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // the edge that releases reset still clears the pins, so every
    // antecedent also needs reset_n sampled high at its own edge
    sequence s_no_force_high;
        reset_n && !fault_force && !cfg.override_enable_high;
    endsequence

    sequence s_no_force_low;
        reset_n && !fault_force && !cfg.override_enable_low;
    endsequence

    sequence s_pp_rise;
        reset_n && cfg.pin_pair_mode == MODE_PUSH_PULL
        && gen.high && !gen_high_r;
    endsequence

    sequence s_pp_quiet;
        reset_n && cfg.pin_pair_mode == MODE_PUSH_PULL
        && !fault_force && !cfg.override_enable_high
        && !cfg.override_enable_low;
    endsequence

    sequence s_fault_normal;
        reset_n && fault_active
        && cfg.independent_fault_sel == FAULT_MODE_NORMAL;
    endsequence

    sequence s_fault_other;
        reset_n && fault_active
        && cfg.independent_fault_sel != FAULT_MODE_NORMAL;
    endsequence

    a_low_polarity: assert property (
        s_no_force_low and cfg.pin_pair_mode == MODE_INDEPENDENT
        |=> low_side_pin == ($past(gen.low) ^ $past(cfg.low_polarity_inv)))
    else $error("low pin polarity wrong");

    a_mode_compl: assert property (
        s_no_force_high and s_no_force_low
        and cfg.pin_pair_mode == MODE_COMPLEMENTARY
        |=> low_side_pin == (~high_side_pin ^ $past(cfg.low_polarity_inv)))
    else $error("complementary pins not opposite");

    a_mode_redundant: assert property (
        s_no_force_high and s_no_force_low
        and cfg.pin_pair_mode == MODE_REDUNDANT
        |=> high_side_pin == $past(gen.high)
        && low_side_pin == ($past(gen.high) ^ $past(cfg.low_polarity_inv)))
    else $error("redundant pins differ from generator");

    a_push_alternate: assert property (
        reset_n && gen.high && !gen_high_r
        |=> phase_r != $past(phase_r))
    else $error("push-pull phase did not alternate");

    a_push_phase_pin: assert property (
        s_pp_rise and s_pp_quiet
        |=> high_side_pin == ($past(phase_r) == POC_PH_LOW))
    else $error("push-pull period started on the wrong pin");

    a_push_one_pin: assert property (
        s_pp_quiet
        |=> (high_side_pin | (low_side_pin ^ $past(cfg.low_polarity_inv)))
        == $past(gen.high))
    else $error("push-pull waveform missing from both pins");

    a_push_exclusive: assert property (
        s_pp_quiet
        |=> !(high_side_pin
        && (low_side_pin ^ $past(cfg.low_polarity_inv))))
    else $error("push-pull drove both pins");

    a_mode_indep_high: assert property (
        s_no_force_high and cfg.pin_pair_mode == MODE_INDEPENDENT
        |=> high_side_pin == $past(gen.high))
    else $error("independent high pin differs from generator");

    a_compl_high: assert property (
        s_no_force_high and cfg.pin_pair_mode == MODE_COMPLEMENTARY
        |=> high_side_pin == $past(gen.high))
    else $error("complementary high pin differs from generator");

    a_override_high: assert property (
        reset_n && !fault_force && cfg.override_enable_high
        |=> high_side_pin == $past(cfg.override_value_field[VALUE_HIGH_BIT]))
    else $error("high override not applied");

    a_override_low: assert property (
        reset_n && !fault_force && cfg.override_enable_low
        |=> low_side_pin == ($past(cfg.override_value_field[VALUE_LOW_BIT])
        ^ $past(cfg.low_polarity_inv)))
    else $error("low override not applied");

    a_fault_high: assert property (
        s_fault_normal
        |=> high_side_pin == $past(cfg.fault_value_field[VALUE_HIGH_BIT]))
    else $error("high fault state not applied");

    a_fault_low: assert property (
        s_fault_normal
        |=> low_side_pin == $past(cfg.fault_value_field[VALUE_LOW_BIT]))
    else $error("low fault state not applied");

    a_fault_mode_off: assert property (
        s_fault_other and cfg.pin_pair_mode == MODE_INDEPENDENT
        and !cfg.override_enable_high and !cfg.override_enable_low
        |=> high_side_pin == $past(gen.high)
        && low_side_pin == ($past(gen.low) ^ $past(cfg.low_polarity_inv)))
    else $error("fault forced pins outside normal fault mode");

    a_fault_over_low: assert property (
        s_fault_normal and cfg.override_enable_low
        |=> low_side_pin == $past(cfg.fault_value_field[VALUE_LOW_BIT]))
    else $error("low override beat fault state");

    a_fault_priority: assert property (
        reset_n && fault_force && cfg.override_enable_high
        && cfg.override_enable_low
        |=> high_side_pin == $past(cfg.fault_value_field[VALUE_HIGH_BIT])
        && low_side_pin == $past(cfg.fault_value_field[VALUE_LOW_BIT]))
    else $error("override beat fault state");

endmodule // poc_pin_ctrl

// ===== tb/poc_gate_drv.sv
// gate driver stand-in that sits on the pin pair
module poc_gate_drv (
    input wire logic high_side_pin,
    input wire logic low_side_pin,
    input wire logic low_polarity_inv,
    output logic high_gate_on,
    output logic low_gate_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // no dead time of its own: shoot-through shows at once
    assign high_gate_on = high_side_pin;
    assign low_gate_on = low_side_pin ^ low_polarity_inv;
endmodule // poc_gate_drv

// ===== tb/pwm_output_pin_control_bench.sv
// self-checking bench for the pwm pin pair output stage
module pwm_output_pin_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import poc_pkg::*;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    poc_cfg_t cfg = '0;
    poc_wave_t gen = '0;
    logic fault_active = 1'h0;
    logic high_side_pin;
    logic low_side_pin;
    logic high_gate_on;
    logic low_gate_on;
    poc_cfg_t c;
    int error_cnt = 0;
    int comparisons = 0;

    poc_pin_ctrl uut (.core_clk(core_clk), .reset_n(reset_n), .cfg(cfg),
        .gen(gen), .fault_active(fault_active),
        .high_side_pin(high_side_pin), .low_side_pin(low_side_pin));
    poc_gate_drv drv (.high_side_pin(high_side_pin),
        .low_side_pin(low_side_pin),
        .low_polarity_inv(cfg.low_polarity_inv),
        .high_gate_on(high_gate_on), .low_gate_on(low_gate_on));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic poc_cfg_t mk(logic [1:0] m, logic p, logic [1:0] oe,
        logic [1:0] ov, logic [1:0] fv, logic s);
        return {m, p, oe, ov, fv, s};
    endfunction

    task automatic chk(logic [1:0] got, logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // gate pair as the power stage sees it, asserted level decoded
    task automatic chk_gate(logic [1:0] got, logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected gate at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    // each vector is held two samples; checked after the first one
    task automatic step(poc_cfg_t cv, logic [1:0] g, logic f,
        logic [1:0] e);
        @(posedge core_clk);
        cfg <= cv;
        gen <= g;
        fault_active <= f;
        @(posedge core_clk);
        #1;
        chk({high_side_pin, low_side_pin}, e);
        chk_gate({high_gate_on, low_gate_on},
            {e[1], e[0] ^ cv.low_polarity_inv});
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // tests need about 50 cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        chk({high_side_pin, low_side_pin}, 2'h0);
        reset_n <= 1'h1;
        // push-pull first, while the phase is known from reset:
        // the first period goes to the high pin, the next to the low pin
        c = mk(MODE_PUSH_PULL, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0);
        step(c, 2'h0, 1'h0, 2'h0);
        step(c, 2'h2, 1'h0, 2'h2);
        step(c, 2'h2, 1'h0, 2'h2);
        step(c, 2'h0, 1'h0, 2'h0);
        step(c, 2'h2, 1'h0, 2'h1);
        step(c, 2'h2, 1'h0, 2'h1);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0);
        step(c, 2'h2, 1'h0, 2'h2);
        step(c, 2'h1, 1'h0, 2'h1);
        c = mk(MODE_REDUNDANT, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0);
        step(c, 2'h2, 1'h0, 2'h3);
        step(c, 2'h1, 1'h0, 2'h0);
        c = mk(MODE_COMPLEMENTARY, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0);
        step(c, 2'h2, 1'h0, 2'h2);
        step(c, 2'h1, 1'h0, 2'h1);
        c = mk(MODE_INDEPENDENT, 1'h1, 2'h0, 2'h0, 2'h0, 1'h0);
        step(c, 2'h0, 1'h0, 2'h1);
        step(c, 2'h3, 1'h0, 2'h2);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h2, 2'h2, 2'h0, 1'h0);
        step(c, 2'h0, 1'h0, 2'h2);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h3, 2'h1, 2'h0, 1'h0);
        step(c, 2'h2, 1'h0, 2'h1);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h1, 2'h1, 2'h0, 1'h0);
        step(c, 2'h2, 1'h0, 2'h3);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h0, 2'h0, 2'h2, 1'h0);
        step(c, 2'h1, 1'h1, 2'h2);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h0, 2'h0, 2'h1, 1'h0);
        step(c, 2'h2, 1'h1, 2'h1);
        // fault value must win over override, and skips low polarity
        c = mk(MODE_INDEPENDENT, 1'h1, 2'h3, 2'h2, 2'h1, 1'h0);
        step(c, 2'h0, 1'h1, 2'h1);
        c = mk(MODE_INDEPENDENT, 1'h0, 2'h0, 2'h0, 2'h3, 1'h1);
        step(c, 2'h0, 1'h1, 2'h0);
        wrap_up();
    end
endmodule // pwm_output_pin_control_bench
